// >>> core/cas_regs.vh
// Purpose: constants for the core architectural state block
// Assumes: included by bare name from core files
// Notes: registers sit on an Avalon-MM slave, word addressed by byte offset
`ifndef CAS_REGS_VH
`define CAS_REGS_VH
// register byte offsets
`define CAS_OFF_CTRL 8'h00
`define CAS_OFF_STATUS 8'h04
`define CAS_OFF_PC 8'h08
`define CAS_OFF_EPC 8'h0C
`define CAS_OFF_EXC 8'h10
`define CAS_OFF_SETSEL 8'h14
// control field positions
`define CAS_CTRL_USER 0
`define CAS_CTRL_FLIP 1
`define CAS_CTRL_FRW 2
// status field positions
`define CAS_ST_LINK_RESERVATION_FLAG 0
`define CAS_ST_BIGMEM 1
`define CAS_ST_LSBIG 2
`define CAS_ST_SWAP 3
`define CAS_ST_ISA 4
`define CAS_ST_DSLOT 5
`define CAS_ST_FCC0 6
`define CAS_ST_FP64 7
// reset values
`define CAS_PC_RESET 32'hBFC00000
`define CAS_CTRL_RESET 32'h00000000
// pc increments
`define CAS_INC_SHORT 32'h00000002
`define CAS_INC_LONG 32'h00000004
`endif

// >>> core/cas_gpr_file.v
// Purpose: banked general register file with hard-wired zero register
// Assumes: one write and two reads per cycle, reads are combinational
// Notes: flip-flop storage indexed by set and register number
`timescale 1ns/1ns
`default_nettype none
module cas_gpr_file #(
	parameter WIDTH = 32,
	parameter SETS = 2,
	parameter SETW = 1
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// selected shadow set
	input wire [SETW-1:0] set_sel,
	// write port
	input wire wr_en,
	input wire [4:0] wr_idx,
	input wire [WIDTH-1:0] wr_data,
	// read ports
	input wire [4:0] ra_idx,
	output wire [WIDTH-1:0] ra_data,
	input wire [4:0] rb_idx,
	output wire [WIDTH-1:0] rb_data
);
	reg [WIDTH-1:0] mem_r [0:SETS*32-1];
	integer i;

	// flat index of a register within the selected set
	function [SETW+4:0] flat;
		input [SETW-1:0] s;
		input [4:0] r;
		begin
			flat = {s, r};
		end
	endfunction

	// write discards register zero
	always @(posedge clk) begin
		if (rst) begin
			for (i = 0; i < SETS*32; i = i + 1)
				mem_r[i] <= {WIDTH{1'b0}};
		end else if (wr_en && wr_idx != 5'h00) begin
			mem_r[flat(set_sel, wr_idx)] <= wr_data;
		end
	end

	// register zero always reads zero
	assign ra_data = (ra_idx == 5'h00) ? {WIDTH{1'b0}} : mem_r[flat(set_sel, ra_idx)];
	assign rb_data = (rb_idx == 5'h00) ? {WIDTH{1'b0}} : mem_r[flat(set_sel, rb_idx)];
endmodule // cas_gpr_file
`default_nettype wire

// >>> core/cas_core_state.v
// Purpose: architectural state and program counter sequencing of a core
// Assumes: one instruction retires per step pulse; decode lies outside
// Notes: software view over Avalon-MM slave, fixed one wait cycle
//
// Functional notes
// - reading general register zero always returns zero
// - register accesses go to the set chosen by current_shadow_set
// - general register width is a build parameter, 32 or 64
// - mem_big_endian_cfg captured on first clock after reset release; sets memory and kernel byte order
// - load_store_big_endian is mem_big_endian_cfg xor user_endian_swap
// - user_endian_swap only when flip bit set and in user mode
// - linked load sets reservation; conditional store tests it; conflicts clear it
// - exception return clears the reservation flag
// - pc advances by 2 after compressed, else 4, when not assigned
// - taken branch loads target during delay slot instruction
// - link writes restart address plus 8 to register; exception to system register
// - one-bit instr_set_select: 0 is 32-bit, 1 is compressed
// - restart values combine upper pc bits with instr_set_select
// - program counter holds a full 32-bit address used whole
// - float_reg_width_select chooses 32x32 or 32x64 floating registers
// - first-release 32-bit builds fix narrow mode, pairs for 64-bit data
// - in_delay_slot_flag true only when executing in a real delay slot
// - exception carries type and argument; later effects are suppressed
// - effects of one instruction in order; later-time effects land later
// - fp condition code 0 equals coprocessor condition signal 1
// - physical address width is build parameter phys_addr_width
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "cas_regs.vh"
module cas_core_state #(
	parameter GENERAL_REGISTER_WIDTH = 32,
	parameter SHADOW_SETS = 2,
	parameter SETW = 1,
	parameter PHYS_ADDR_WIDTH = 32,
	parameter HAS_COMPRESSED = 1,
	parameter FIRST_RELEASE = 0
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// reset-time strap
	input wire mem_big_endian_cfg,
	// instruction step from decode
	input wire step,
	input wire step_short,
	input wire step_branch_taken,
	input wire [31:0] step_target,
	input wire step_set_isa,
	input wire step_isa_val,
	input wire step_link,
	input wire [4:0] step_link_reg,
	input wire step_linked_load,
	input wire [31:0] step_ll_addr,
	input wire step_cond_store,
	input wire step_store,
	input wire [31:0] step_store_addr,
	input wire step_eret,
	input wire step_exc,
	input wire [4:0] step_exc_type,
	input wire [31:0] step_exc_arg,
	// general register ports
	input wire gpr_wr_en,
	input wire [4:0] gpr_wr_idx,
	input wire [GENERAL_REGISTER_WIDTH-1:0] gpr_wr_data,
	input wire [4:0] gpr_ra_idx,
	input wire [4:0] gpr_rb_idx,
	output reg [GENERAL_REGISTER_WIDTH-1:0] gpr_ra_data_r,
	output reg [GENERAL_REGISTER_WIDTH-1:0] gpr_rb_data_r,
	// coprocessor condition signals
	input wire [3:0] coproc_condition_signal,
	// architectural state outputs
	output reg [31:0] program_counter_r,
	output reg [PHYS_ADDR_WIDTH-1:0] phys_addr_r,
	output reg instr_set_select_r,
	output reg in_delay_slot_flag_r,
	output reg link_reservation_flag_r,
	output reg sc_success_r,
	output reg load_store_big_endian_r,
	output reg user_endian_swap_r,
	output reg kernel_big_endian_r,
	output reg fp64_regs_r,
	output reg fp_condition_code0_r,
	output reg exc_valid_r,
	output reg [4:0] exc_type_r,
	output reg [31:0] exc_arg_r,
	output reg [31:0] exc_restart_r,
	// Avalon-MM slave
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [31:0] ctrl_r;
	reg big_mem_r;
	reg strap_pending_r;
	reg branch_pending_r;
	reg [31:0] branch_target_r;
	reg [31:0] ll_addr_r;
	reg [SETW-1:0] current_shadow_set_r;
	reg ack_r;
	reg [31:0] pc_nxt;
	reg [GENERAL_REGISTER_WIDTH-1:0] link_val;
	wire [GENERAL_REGISTER_WIDTH-1:0] ra_w;
	wire [GENERAL_REGISTER_WIDTH-1:0] rb_w;
	wire gwr_en;
	wire [4:0] gwr_idx;
	wire [GENERAL_REGISTER_WIDTH-1:0] gwr_data;
	wire user_mode;
	wire flip_bit;
	wire swap;
	wire frw;
	wire [31:0] restart;
	wire [31:0] status_w;
	wire [31:0] inc;
	wire store_hits;

	// width must be 32 or 64
	localparam WIDTH_OK = (GENERAL_REGISTER_WIDTH == 32) || (GENERAL_REGISTER_WIDTH == 64);
	localparam GW = WIDTH_OK ? GENERAL_REGISTER_WIDTH : 32;

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	assign user_mode = ctrl_r[`CAS_CTRL_USER];
	assign flip_bit = ctrl_r[`CAS_CTRL_FLIP];
	assign swap = flip_bit & user_mode;
	// narrow mode fixed in first-release builds
	assign frw = (FIRST_RELEASE != 0) ? 1'b0 : ctrl_r[`CAS_CTRL_FRW];
	// restart value keeps upper pc bits and the set-select bit in bit 0
	assign restart = {program_counter_r[31:1], instr_set_select_r};
	assign inc = step_short ? `CAS_INC_SHORT : `CAS_INC_LONG;
	assign store_hits = step_store && (step_store_addr[31:2] == ll_addr_r[31:2]);

	// link write takes the register port, exceptions suppress it
	assign gwr_en = (step && step_link && !step_exc) ? 1'b1 : gpr_wr_en;
	assign gwr_idx = (step && step_link && !step_exc) ? step_link_reg : gpr_wr_idx;
	assign gwr_data = (step && step_link && !step_exc) ? link_val : gpr_wr_data;

	// link value widened to register width
	always @* begin
		link_val = {GENERAL_REGISTER_WIDTH{1'b0}};
		link_val[31:0] = restart + 32'h00000008;
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	cas_gpr_file #(
		.WIDTH(GENERAL_REGISTER_WIDTH),
		.SETS(SHADOW_SETS),
		.SETW(SETW)
	) u_gpr (
		.clk(clk),
		.rst(rst),
		.set_sel(current_shadow_set_r),
		.wr_en(gwr_en),
		.wr_idx(gwr_idx),
		.wr_data(gwr_data),
		.ra_idx(gpr_ra_idx),
		.ra_data(ra_w),
		.rb_idx(gpr_rb_idx),
		.rb_data(rb_w)
	);

	// registered read data
	always @(posedge clk) begin
		if (rst) begin
			gpr_ra_data_r <= {GENERAL_REGISTER_WIDTH{1'b0}};
			gpr_rb_data_r <= {GENERAL_REGISTER_WIDTH{1'b0}};
		end else begin
			gpr_ra_data_r <= ra_w;
			gpr_rb_data_r <= rb_w;
		end
	end

	// ----------------------------------------------------------------
	// program counter sequencing
	// ----------------------------------------------------------------
	// next pc: pending branch lands after the delay slot instruction
	always @* begin
		pc_nxt = program_counter_r + inc;
		if (branch_pending_r)
			pc_nxt = branch_target_r;
	end

	always @(posedge clk) begin
		if (rst) begin
			program_counter_r <= `CAS_PC_RESET;
			branch_pending_r <= 1'b0;
			branch_target_r <= 32'h00000000;
			in_delay_slot_flag_r <= 1'b0;
			instr_set_select_r <= 1'b0;
			exc_valid_r <= 1'b0;
			exc_type_r <= 5'h00;
			exc_arg_r <= 32'h00000000;
			exc_restart_r <= 32'h00000000;
		end else begin
			exc_valid_r <= 1'b0;
			if (step) begin
				if (step_exc) begin
					// exception stops the instruction where raised
					exc_valid_r <= 1'b1;
					exc_type_r <= step_exc_type;
					exc_arg_r <= step_exc_arg;
					exc_restart_r <= restart;
					branch_pending_r <= 1'b0;
					in_delay_slot_flag_r <= 1'b0;
				end else begin
					program_counter_r <= pc_nxt;
					// the next instruction is in a slot only if this one branched
					in_delay_slot_flag_r <= step_branch_taken;
					branch_pending_r <= step_branch_taken;
					if (step_branch_taken)
						branch_target_r <= step_target;
					if (step_set_isa && HAS_COMPRESSED != 0)
						instr_set_select_r <= step_isa_val;
				end
			end
		end
	end

	// physical address view of the pc
	always @(posedge clk) begin
		if (rst)
			phys_addr_r <= {PHYS_ADDR_WIDTH{1'b0}};
		else
			phys_addr_r <= program_counter_r[PHYS_ADDR_WIDTH-1:0];
	end

	// ----------------------------------------------------------------
	// reservation flag
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			link_reservation_flag_r <= 1'b0;
			ll_addr_r <= 32'h00000000;
			sc_success_r <= 1'b0;
		end else if (step && !step_exc) begin
			sc_success_r <= step_cond_store & link_reservation_flag_r;
			if (step_eret) begin
				link_reservation_flag_r <= 1'b0;
			end else if (step_linked_load) begin
				link_reservation_flag_r <= 1'b1;
				ll_addr_r <= step_ll_addr;
			end else if (step_cond_store || store_hits) begin
				link_reservation_flag_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// byte order and floating modes
	// ----------------------------------------------------------------
	// strap caught on the first clock after reset release
	always @(posedge clk) begin
		if (rst) begin
			strap_pending_r <= 1'b1;
			big_mem_r <= 1'b0;
		end else if (strap_pending_r) begin
			strap_pending_r <= 1'b0;
			big_mem_r <= mem_big_endian_cfg;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			user_endian_swap_r <= 1'b0;
			load_store_big_endian_r <= 1'b0;
			kernel_big_endian_r <= 1'b0;
			fp64_regs_r <= 1'b0;
			fp_condition_code0_r <= 1'b0;
		end else begin
			user_endian_swap_r <= swap;
			load_store_big_endian_r <= big_mem_r ^ swap;
			kernel_big_endian_r <= big_mem_r;
			fp64_regs_r <= frw;
			fp_condition_code0_r <= coproc_condition_signal[1];
		end
	end

	// ----------------------------------------------------------------
	// Avalon-MM register slave
	// ----------------------------------------------------------------
	assign status_w = {24'h000000, fp64_regs_r, fp_condition_code0_r,
		in_delay_slot_flag_r, instr_set_select_r, user_endian_swap_r,
		load_store_big_endian_r, big_mem_r, link_reservation_flag_r};

	// one wait cycle then answer
	always @(posedge clk) begin
		if (rst) begin
			ack_r <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
			ctrl_r <= `CAS_CTRL_RESET;
			current_shadow_set_r <= {SETW{1'b0}};
		end else begin
			ack_r <= 1'b0;
			avs_waitrequest <= 1'b1;
			if ((avs_read || avs_write) && !ack_r && avs_waitrequest) begin
				ack_r <= 1'b1;
				avs_waitrequest <= 1'b0;
				if (avs_write && avs_byteenable[0]) begin
					case (avs_address)
					`CAS_OFF_CTRL: ctrl_r[7:0] <= {5'h00, avs_writedata[2:0]};
					`CAS_OFF_SETSEL: current_shadow_set_r <= avs_writedata[SETW-1:0];
					default: ;
					endcase
				end
				if (avs_read) begin
					case (avs_address)
					`CAS_OFF_CTRL: avs_readdata <= ctrl_r;
					`CAS_OFF_STATUS: avs_readdata <= status_w;
					`CAS_OFF_PC: avs_readdata <= program_counter_r;
					`CAS_OFF_EPC: avs_readdata <= exc_restart_r;
					`CAS_OFF_EXC: avs_readdata <= {27'h0000000, exc_type_r};
					`CAS_OFF_SETSEL: avs_readdata <= {{(32-SETW){1'b0}}, current_shadow_set_r};
					default: avs_readdata <= 32'h00000000;
					endcase
				end
			end
		end
	end
endmodule // cas_core_state
`default_nettype wire

// >>> tb/cas_copro_model.sv
// Purpose: coprocessor condition source standing beside the core state block
// Assumes: runs on the core clock, restarted by the core reset
// Notes: the pattern moves every cycle so a stale or late sample shows up
`timescale 1ns/1ns
`default_nettype none
module cas_copro_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// condition signals toward the core
	output logic [3:0] cond
);
	// --------
	// pattern
	// --------
	// four-bit shift walk, never all zero
	always @(posedge clk) begin
		if (rst)
			cond <= 4'h1;
		else
			cond <= {cond[2:0], cond[3] ^ cond[2]};
	end
endmodule // cas_copro_model
`default_nettype wire

// >>> tb/cas_core_properties.sv
// Purpose: concurrent checks on the core architectural state block
// Assumes: one clock domain, bound into every core state instance
// Notes: helper logic holds the pending branch target for the delay slot
`timescale 1ns/1ns
`default_nettype none
`include "cas_regs.vh"
module cas_core_props #(
	parameter GENERAL_REGISTER_WIDTH = 32,
	parameter PHYS_ADDR_WIDTH = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// step qualifiers
	input wire logic step,
	input wire logic step_short,
	input wire logic step_branch_taken,
	input wire logic [31:0] step_target,
	input wire logic step_linked_load,
	input wire logic step_cond_store,
	input wire logic step_eret,
	input wire logic step_exc,
	input wire logic [4:0] step_exc_type,
	input wire logic [31:0] step_exc_arg,
	// register read and coprocessor
	input wire logic [4:0] gpr_ra_idx,
	input wire logic [GENERAL_REGISTER_WIDTH-1:0] gpr_ra_data_r,
	input wire logic [3:0] coproc_condition_signal,
	// state outputs
	input wire logic [31:0] program_counter_r,
	input wire logic [PHYS_ADDR_WIDTH-1:0] phys_addr_r,
	input wire logic instr_set_select_r,
	input wire logic in_delay_slot_flag_r,
	input wire logic link_reservation_flag_r,
	input wire logic sc_success_r,
	input wire logic load_store_big_endian_r,
	input wire logic user_endian_swap_r,
	input wire logic kernel_big_endian_r,
	input wire logic fp_condition_code0_r,
	input wire logic exc_valid_r,
	input wire logic [4:0] exc_type_r,
	input wire logic [31:0] exc_arg_r,
	input wire logic [31:0] exc_restart_r,
	// bus handshake
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// --------
	// helpers
	// --------
	// a taken branch leaves its target waiting for the delay slot step
	logic pend_r;
	logic [31:0] tgt_r;
	always @(posedge clk) begin
		if (rst)
			pend_r <= 1'b0;
		else if (step)
			pend_r <= step_branch_taken && !step_exc; // an exception drops the pending branch
		if (step && step_branch_taken && !step_exc)
			tgt_r <= step_target;
	end
	// --------
	// properties
	// --------
	sequence s_exc_req;
		step && step_exc;
	endsequence
	sequence s_exc_ans;
		exc_valid_r && exc_type_r == $past(step_exc_type) && exc_arg_r == $past(step_exc_arg);
	endsequence
	property p_exc;
		s_exc_req |=> s_exc_ans ##0 program_counter_r == $past(program_counter_r)
			##0 exc_restart_r == ($past(program_counter_r) & 32'hFFFFFFFE | $past(instr_set_select_r));
	endproperty
	a_exc: assert property (p_exc) else $error("exception report wrong");
	property p_seq;
		step && !step_exc && !pend_r |=> program_counter_r == $past(program_counter_r)
			+ ($past(step_short) ? `CAS_INC_SHORT : `CAS_INC_LONG);
	endproperty
	a_seq: assert property (p_seq) else $error("pc advance wrong");
	property p_tgt;
		step && !step_exc && pend_r |=> program_counter_r == $past(tgt_r);
	endproperty
	a_tgt: assert property (p_tgt) else $error("branch target not taken after slot");
	property p_dslot;
		step && !step_exc |=> in_delay_slot_flag_r == $past(step_branch_taken);
	endproperty
	a_dslot: assert property (p_dslot) else $error("delay slot flag wrong");
	property p_ll;
		step && step_linked_load && !step_eret && !step_exc |=> link_reservation_flag_r;
	endproperty
	a_ll: assert property (p_ll) else $error("reservation not set");
	property p_sc;
		step && step_cond_store && !step_exc
			|=> sc_success_r == $past(link_reservation_flag_r) && !link_reservation_flag_r;
	endproperty
	a_sc: assert property (p_sc) else $error("conditional store result wrong");
	property p_eret;
		step && step_eret && !step_exc |=> !link_reservation_flag_r;
	endproperty
	a_eret: assert property (p_eret) else $error("return kept reservation");
	property p_zero;
		!$past(rst) && $past(gpr_ra_idx) == 5'h00 |-> gpr_ra_data_r == '0;
	endproperty
	a_zero: assert property (p_zero) else $error("register zero not zero");
	property p_fcc;
		!$past(rst) |-> fp_condition_code0_r == $past(coproc_condition_signal[1]);
	endproperty
	a_fcc: assert property (p_fcc) else $error("condition code zero wrong");
	property p_phys;
		!$past(rst) |-> phys_addr_r == $past(program_counter_r[PHYS_ADDR_WIDTH-1:0]);
	endproperty
	a_phys: assert property (p_phys) else $error("physical address wrong");
	property p_xor;
		!$past(rst) && $stable(user_endian_swap_r) && $stable(kernel_big_endian_r)
			|-> load_store_big_endian_r == (kernel_big_endian_r ^ user_endian_swap_r);
	endproperty
	a_xor: assert property (p_xor) else $error("load store order wrong");
	property p_avs;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_avs: assert property (p_avs) else $error("bus answer late");
endmodule // cas_core_props
bind cas_core_state cas_core_props #(
	.GENERAL_REGISTER_WIDTH(GENERAL_REGISTER_WIDTH),
	.PHYS_ADDR_WIDTH(PHYS_ADDR_WIDTH)
) cas_core_props_i (.*);
`default_nettype wire

// >>> tb/tb.sv
// Purpose: self-checking bench for the core architectural state block
// Assumes: one wait cycle on the register bus, steps spaced by idle cycles
// Notes: random step streams mixed with fixed corner sequences
`timescale 1ns/1ns
`default_nettype none
`include "cas_regs.vh"
module tb;
	// --------
	// signals
	// --------
	logic clk, rst, mem_big_endian_cfg, step, step_short, step_branch_taken, step_set_isa;
	logic step_isa_val, step_link, step_linked_load, step_cond_store, step_store, step_eret;
	logic step_exc, gpr_wr_en, instr_set_select_r, in_delay_slot_flag_r, link_reservation_flag_r;
	logic sc_success_r, load_store_big_endian_r, user_endian_swap_r, kernel_big_endian_r, pend;
	logic fp64_regs_r, fp_condition_code0_r, exc_valid_r, avs_read, avs_write, avs_waitrequest;
	logic [4:0] step_link_reg, step_exc_type, gpr_wr_idx, gpr_ra_idx, gpr_rb_idx, exc_type_r;
	logic [3:0] coproc_condition_signal, avs_byteenable;
	logic [7:0] avs_address, lf, ls;
	logic [23:0] phys_addr_r;
	logic [31:0] step_target, step_ll_addr, step_store_addr, step_exc_arg, gpr_wr_data, q, v;
	logic [31:0] gpr_ra_data_r, gpr_rb_data_r, program_counter_r, exc_arg_r, exc_restart_r;
	logic [31:0] avs_writedata, avs_readdata, exp_pc, tgt, p;
	logic [31:0] sv [2];
	logic [9:0] lk [8];
	int mismatches, checks_done, cyc;
	cas_core_state #(.PHYS_ADDR_WIDTH(24)) cas_core_state_i (.*);
	cas_copro_model cas_copro_model_i (.clk(clk), .rst(rst), .cond(coproc_condition_signal));
	// --------
	// helpers
	// --------
	// clock at 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			$display("ERROR %0t run timed out", $time);
			stop_test;
		end
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	// expected pc: held on exception, target in the slot, else step size
	function automatic logic [31:0] f_pc(input logic [31:0] pc, input logic [9:0] k);
		if (k[7])
			return pc;
		if (pend)
			return tgt;
		return pc + (k[0] ? `CAS_INC_SHORT : `CAS_INC_LONG);
	endfunction
	task automatic reset(input logic b);
		@(posedge clk);
		rst <= 1'b1;
		mem_big_endian_cfg <= b;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		mem_big_endian_cfg <= !b;
		repeat (2) @(posedge clk);
		#1;
		exp_pc = `CAS_PC_RESET;
		pend = 1'b0;
	endtask
	// one bus cycle, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// one retired instruction, kind bits select the qualifiers
	task automatic do_step(input logic [9:0] k, input logic [31:0] d);
		exp_pc = f_pc(exp_pc, k);
		// an exception drops a branch still waiting for its slot
		if (k[1] && !k[7])
			tgt = d;
		pend = k[1] && !k[7];
		@(posedge clk);
		step <= 1'b1;
		{step_isa_val, step_set_isa, step_exc, step_eret, step_store, step_cond_store} <= k[9:4];
		{step_linked_load, step_link, step_branch_taken, step_short} <= k[3:0];
		step_target <= d;
		step_ll_addr <= d;
		step_store_addr <= d;
		step_exc_arg <= d;
		step_exc_type <= d[6:2];
		@(posedge clk);
		step <= 1'b0;
		#1;
		chk(program_counter_r, exp_pc, "pc");
		chk(exc_valid_r, k[7], "exception pulse");
		if (k[7])
			chk(exc_arg_r, d, "exception argument");
	endtask
	task automatic gw(input logic [4:0] i, input logic [31:0] d);
		@(posedge clk);
		gpr_wr_en <= 1'b1;
		gpr_wr_idx <= i;
		gpr_wr_data <= d;
		@(posedge clk);
		gpr_wr_en <= 1'b0;
	endtask
	task automatic gr(input logic [4:0] i, input logic [31:0] e, input string m);
		@(posedge clk);
		gpr_ra_idx <= i;
		gpr_rb_idx <= i;
		@(posedge clk);
		#1;
		chk(gpr_ra_data_r, e, m);
		chk(gpr_rb_data_r, e, m);
	endtask
	// --------
	// scenarios
	// --------
	initial begin
		{rst, mem_big_endian_cfg, step, step_short, step_branch_taken, step_set_isa} = 6'h20;
		{step_isa_val, step_link, step_linked_load, step_cond_store, step_store, step_eret} = 6'h00;
		{step_exc, gpr_wr_en, avs_read, avs_write, gpr_wr_idx, gpr_ra_idx, gpr_rb_idx} = 19'h0;
		{step_target, step_ll_addr, step_store_addr, step_exc_arg, gpr_wr_data} = 160'h0;
		{avs_address, avs_writedata, step_exc_type} = 45'h0;
		step_link_reg = 5'h1F;
		avs_byteenable = 4'hF;
		lk = '{10'h008, 10'h010, 10'h010, 10'h008, 10'h020, 10'h008, 10'h040, 10'h048};
		lf = 8'h29;
		ls = 8'h02;
		v = $urandom(32'hEC9AED05);
		for (int b = 0; b < 2; b++) begin
			reset(b[0]);
			chk(program_counter_r, `CAS_PC_RESET, "pc reset");
			bus(1'b1, 8'h40, 32'hFFFFFFFF);
			bus(1'b0, 8'h40, 32'h0);
			chk(q, 32'h0, "unmapped read");
			bus(1'b0, `CAS_OFF_CTRL, 32'h0);
			chk(q, `CAS_CTRL_RESET, "control reset");
			for (int c = 0; c < 8; c++) begin
				bus(1'b1, `CAS_OFF_CTRL, c);
				repeat (3) @(posedge clk);
				#1;
				chk(user_endian_swap_r, c[0] & c[1], "swap");
				chk(kernel_big_endian_r, b[0], "kernel order");
				chk(load_store_big_endian_r, b[0] ^ c[0] & c[1], "load store order");
				chk(fp64_regs_r, c[2], "float width");
			end
			bus(1'b0, `CAS_OFF_STATUS, 32'h0);
			chk(q[`CAS_ST_BIGMEM], b[0], "status order");
		end
		bus(1'b1, `CAS_OFF_CTRL, 32'h0);
		for (int n = 0; n < 80; n++) begin
			v = $urandom;
			do_step({2'b00, !pend && v[9:8] == 2'b11, 5'h00, !pend && v[1], v[0]},
				$urandom & 32'hFFFFFFFC);
		end
		// branch whose delay slot raises an exception, then a plain step
		do_step(10'h002, 32'h00000400);
		do_step(10'h080, 32'h00000010);
		do_step(10'h000, 32'h0);
		do_step(10'h300, 32'h0);
		p = exp_pc;
		do_step(10'h080, 32'h0000007C);
		chk(exc_restart_r, {p[31:1], 1'b1}, "restart value");
		do_step(10'h100, 32'h0);
		p = exp_pc;
		do_step(10'h004, 32'h0);
		gr(5'h1F, p + 32'h8, "link value");
		foreach (lk[i]) begin
			do_step(lk[i], 32'h00001000);
			chk(link_reservation_flag_r, lf[i], "reservation");
			if (lk[i][4])
				chk(sc_success_r, ls[i], "conditional store");
		end
		gw(5'h00, 32'hFFFFFFFF);
		gr(5'h00, 32'h0, "register zero");
		for (int s = 0; s < 2; s++) begin
			sv[s] = $urandom;
			bus(1'b1, `CAS_OFF_SETSEL, s);
			gw(5'h07, sv[s]);
		end
		for (int s = 0; s < 2; s++) begin
			bus(1'b1, `CAS_OFF_SETSEL, s);
			gr(5'h07, sv[s], "shadow set");
		end
		@(posedge clk);
		v[0] = coproc_condition_signal[1];
		#1;
		chk(fp_condition_code0_r, v[0], "condition code");
		bus(1'b0, `CAS_OFF_PC, 32'h0);
		chk(q, exp_pc, "pc register");
		stop_test;
	end
endmodule // tb
`default_nettype wire
